// ### src/mfr_modes_fruit_reply_data_gen.sv
// mode s fruit reply data generator with apb ratio and status registers
`timescale 1ns/1ps
module mfr_modes_fruit_reply_data_gen (
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [mfr_pkg::APB_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cmd_reset,
   input wire logic leading_words_read_cmd,
   input wire logic trailing_words_read_cmd,
   input wire logic [15:0] param_word0,
   input wire logic [15:0] param_word1,
   input wire logic [15:0] param_word2,
   output logic [15:0] word_data,
   output logic word_valid
);
   mfr_pkg::mfr_state_type state;
   logic [mfr_pkg::STEP_W-1:0] step;
   logic [mfr_pkg::RATIO_W-1:0] ratio;
   logic [2:0] format_bits_latch;
   logic [mfr_pkg::LS_W-1:0] long_short_random_source;
   logic [mfr_pkg::FW_W-1:0] first_word_random_source;
   logic [mfr_pkg::TW_W-1:0] trailing_word_random_source;
   logic long_sel;
   logic [15:0] first_word;
   logic sequence_active_flag;
   logic accept_lead;
   logic accept_trail;
   logic first_read;
   logic trail_read;
   logic apb_setup;
   logic apb_done;
   logic [3:0] seq_sel;
   logic [7:0] first_byte_selector;
   logic [7:0] second_byte_selector;
   logic [7:0] rnd_lo;
   logic [7:0] id_lo;
   logic [7:0] ac_lo;

   // ************************************************************
   // apb slave
   // ************************************************************
   // one wait state: pready rises in the second access cycle
   assign apb_setup = psel & penable & ~pready;
   assign apb_done = psel & penable & pready;

   // ready and read data are registered
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (ce)
      begin
         pready <= apb_setup;
         if (apb_setup)
         begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            case (paddr)
               mfr_pkg::RATIO_OFS: prdata[mfr_pkg::RATIO_W-1:0] <= ratio;
               mfr_pkg::STATUS_OFS:
               begin
                  prdata[mfr_pkg::ST_SEQ_BIT] <= sequence_active_flag;
                  prdata[mfr_pkg::ST_LONG_BIT] <= long_sel;
                  prdata[mfr_pkg::ST_FMT_LSB +: 3] <= format_bits_latch;
                  prdata[mfr_pkg::ST_LEAD_BIT] <= (state == mfr_pkg::ST_LEAD);
               end
               default: pslverr <= 1'b1; // unmapped address
            endcase
         end
      end
   end

   // long ratio register, written at the completing edge
   always_ff @(posedge clock)
   begin
      if (srst)
         ratio <= mfr_pkg::RATIO_RST;
      else if (ce && apb_done && pwrite && paddr == mfr_pkg::RATIO_OFS)
         ratio <= pwdata[mfr_pkg::RATIO_W-1:0];
   end

   // ************************************************************
   // random sources
   // ************************************************************
   assign first_read = (state == mfr_pkg::ST_LEAD) && (step == mfr_pkg::FIRST_WORD_STEP);
   assign trail_read = (state == mfr_pkg::ST_TRAIL);

   mfr_lfsr #(
      .W(mfr_pkg::LS_W),
      .TAPS(mfr_pkg::LS_TAPS),
      .SEED(mfr_pkg::LS_SEED)
   ) u_ls_src (
      .clock(clock),
      .srst(srst),
      .ce(ce),
      .reseed(cmd_reset),
      .advance(first_read),
      .state(long_short_random_source)
   );

   mfr_lfsr #(
      .W(mfr_pkg::FW_W),
      .TAPS(mfr_pkg::FW_TAPS),
      .SEED(mfr_pkg::FW_SEED)
   ) u_fw_src (
      .clock(clock),
      .srst(srst),
      .ce(ce),
      .reseed(cmd_reset),
      .advance(first_read),
      .state(first_word_random_source)
   );

   mfr_lfsr #(
      .W(mfr_pkg::TW_W),
      .TAPS(mfr_pkg::TW_TAPS),
      .SEED(mfr_pkg::TW_SEED)
   ) u_tw_src (
      .clock(clock),
      .srst(srst),
      .ce(ce),
      .reseed(cmd_reset),
      .advance(trail_read),
      .state(trailing_word_random_source)
   );

   // ************************************************************
   // long/short decision and first word
   // ************************************************************
   // top ratio bit forces long, so 16..31 all act as 16
   assign long_sel = ratio[mfr_pkg::RATIO_W-1] |
                     (long_short_random_source[3:0] < ratio[3:0]);

   // short replies use the upper half of the table
   mfr_first_word_rom u_rom (
      .addr({~long_sel, first_word_random_source[7:0]}),
      .data(first_word)
   );

   // ************************************************************
   // read sequencer
   // ************************************************************
   assign sequence_active_flag = (state == mfr_pkg::ST_TRAIL);
   assign accept_lead = (state == mfr_pkg::ST_IDLE) && leading_words_read_cmd && !cmd_reset;
   assign accept_trail = (state == mfr_pkg::ST_IDLE) && trailing_words_read_cmd &&
                         !leading_words_read_cmd && !cmd_reset;

   // state and word step; reset command aborts any read
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         state <= mfr_pkg::ST_IDLE;
         step <= 3'h0;
      end
      else if (ce)
      begin
         if (cmd_reset)
         begin
            state <= mfr_pkg::ST_IDLE;
            step <= 3'h0;
         end
         else
         begin
            case (state)
               mfr_pkg::ST_IDLE:
               begin
                  step <= 3'h0;
                  if (accept_lead)
                     state <= mfr_pkg::ST_LEAD;
                  else if (accept_trail)
                     state <= mfr_pkg::ST_TRAIL;
               end
               mfr_pkg::ST_LEAD:
               begin
                  if (step == mfr_pkg::LEAD_LAST)
                  begin
                     state <= mfr_pkg::ST_IDLE;
                     step <= 3'h0;
                  end
                  else
                     step <= step + 3'h1;
               end
               mfr_pkg::ST_TRAIL:
               begin
                  if (step == mfr_pkg::TRAIL_LAST)
                  begin
                     state <= mfr_pkg::ST_IDLE;
                     step <= 3'h0;
                  end
                  else
                     step <= step + 3'h1;
               end
               default:
               begin
                  state <= mfr_pkg::ST_IDLE;
                  step <= 3'h0;
               end
            endcase
         end
      end
   end

   // format bits caught as the first reply word goes out
   always_ff @(posedge clock)
   begin
      if (srst)
         format_bits_latch <= 3'h0;
      else if (ce && !cmd_reset && first_read)
         format_bits_latch <= {first_word[mfr_pkg::DF_LSB + mfr_pkg::FMT_B1],
                               first_word[mfr_pkg::DF_LSB + mfr_pkg::FMT_B2],
                               first_word[mfr_pkg::DF_LSB + mfr_pkg::FMT_B5]};
   end

   // ************************************************************
   // construction sequence and byte selectors
   // ************************************************************
   // sequence table: fmt = {comm-b, all-call, id}, returns {hi, lo}
   function automatic logic [3:0] seq_table(input logic [2:0] fmt,
                                            input logic [mfr_pkg::STEP_W-1:0] s);
      logic [3:0] r;
      r = {mfr_pkg::SEL_ZERO, mfr_pkg::SEL_ZERO};
      if (fmt[1])
      begin
         // all-call: address tail, then zero parity identifier
         if (s == 3'h0)
            r = {mfr_pkg::SEL_RND, mfr_pkg::SEL_RND};
      end
      else
      begin
         case (s)
            3'h0: r = {mfr_pkg::SEL_RND, fmt[0] ? mfr_pkg::SEL_ID : mfr_pkg::SEL_AC};
            3'h1: r = {mfr_pkg::SEL_RND, mfr_pkg::SEL_RND};
            3'h2: r = {mfr_pkg::SEL_RND, fmt[2] ? mfr_pkg::SEL_RND : mfr_pkg::SEL_ZERO};
            default:
            begin
               if (fmt[2])
                  r = {mfr_pkg::SEL_RND, mfr_pkg::SEL_RND};
            end
         endcase
      end
      return r;
   endfunction

   assign seq_sel = seq_table(format_bits_latch, step);
   assign rnd_lo = trailing_word_random_source[7:0];
   // identity low byte: M position forced low
   assign id_lo = rnd_lo & mfr_pkg::ID_MASK;
   // altitude low byte: A4 B1 B2 B4 random, M D1 D2 zero, D4 one in eight
   assign ac_lo = (rnd_lo & mfr_pkg::AC_MASK) |
                  {7'h00, &trailing_word_random_source[20:18]};

   // byte selectors, fourth input grounded
   always_comb
   begin
      first_byte_selector = 8'h00;
      second_byte_selector = 8'h00;
      if (seq_sel[3:2] != mfr_pkg::SEL_ZERO)
         first_byte_selector = trailing_word_random_source[15:8];
      case (seq_sel[1:0])
         mfr_pkg::SEL_RND: second_byte_selector = rnd_lo;
         mfr_pkg::SEL_ID: second_byte_selector = id_lo;
         mfr_pkg::SEL_AC: second_byte_selector = ac_lo;
         default: second_byte_selector = 8'h00;
      endcase
   end

   // ************************************************************
   // word output
   // ************************************************************
   // one word per clock while a read runs
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         word_data <= 16'h0000;
         word_valid <= 1'b0;
      end
      else if (ce)
      begin
         word_valid <= (state != mfr_pkg::ST_IDLE) && !cmd_reset;
         word_data <= 16'h0000;
         if (!cmd_reset && state == mfr_pkg::ST_LEAD)
         begin
            case (step)
               3'h0: word_data <= param_word0;
               3'h1: word_data <= param_word1;
               3'h2: word_data <= param_word2;
               default: word_data <= first_word;
            endcase
         end
         else if (!cmd_reset && state == mfr_pkg::ST_TRAIL)
            word_data <= {first_byte_selector, second_byte_selector};
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   a_ratio_full: assert property (@(posedge clock) disable iff (srst)
      ratio[mfr_pkg::RATIO_W-1] |-> long_sel)
      else $error("long select low with ratio of sixteen or more");

   a_ratio_zero: assert property (@(posedge clock) disable iff (srst)
      (ratio == 5'h00) |-> !long_sel)
      else $error("long select high with zero ratio");

   a_first_fields: assert property (@(posedge clock) disable iff (srst || !ce)
      word_valid && $past(state) == mfr_pkg::ST_LEAD && $past(step) == mfr_pkg::FIRST_WORD_STEP
      && word_data[15:11] != mfr_pkg::DF_ALL_CALL
      |-> word_data[10:8] <= mfr_pkg::FS_MAX && word_data[7:4] == 4'h0)
      else $error("first word status or request field out of range");

   a_first_long: assert property (@(posedge clock) disable iff (srst || !ce)
      first_read && long_sel |=> word_data[15])
      else $error("long reply without long format code");

   a_alt_shape: assert property (@(posedge clock) disable iff (srst || !ce)
      $past(trail_read) && $past(step) == 3'h0 && !format_bits_latch[1] && !format_bits_latch[0]
      |-> word_data[6] == 1'b0 && word_data[4] == 1'b0 && word_data[2] == 1'b0)
      else $error("altitude M or D1 D2 bit set");

   a_allcall_zero: assert property (@(posedge clock) disable iff (srst || !ce)
      $past(trail_read) && $past(step) != 3'h0 && format_bits_latch[1]
      |-> word_data == 16'h0000)
      else $error("all-call tail not zero");

   a_short_tail: assert property (@(posedge clock) disable iff (srst || !ce)
      $past(trail_read) && $past(step) > 3'h2 && !format_bits_latch[2]
      |-> word_data == 16'h0000)
      else $error("short reply carries data past 56 bits");

   a_trail_start: assert property (@(posedge clock) disable iff (srst || !ce)
      accept_trail |=> sequence_active_flag ##1 word_valid)
      else $error("trailing read did not start sequence");

   a_six_words: assert property (@(posedge clock) disable iff (srst || !ce || cmd_reset)
      $rose(sequence_active_flag) |-> sequence_active_flag[*6] ##1 !sequence_active_flag)
      else $error("sequence active not exactly six cycles");

   a_four_words: assert property (@(posedge clock) disable iff (srst || !ce || cmd_reset)
      accept_lead |=> (state == mfr_pkg::ST_LEAD)[*4] ##1 (state == mfr_pkg::ST_IDLE))
      else $error("leading read not four words");

   a_src_advance: assert property (@(posedge clock) disable iff (srst || !ce)
      trail_read && !cmd_reset |=> trailing_word_random_source
                                   != $past(trailing_word_random_source))
      else $error("trailing source did not advance");

   a_reset_seed: assert property (@(posedge clock) disable iff (srst || !ce)
      cmd_reset |=> trailing_word_random_source == mfr_pkg::TW_SEED
                    && long_short_random_source == mfr_pkg::LS_SEED)
      else $error("reset command did not reseed sources");

   c_leading: cover property (@(posedge clock) disable iff (srst) accept_lead ##5 accept_trail);
   c_commb: cover property (@(posedge clock) disable iff (srst)
      $rose(sequence_active_flag) && format_bits_latch[2]);
   c_allcall: cover property (@(posedge clock) disable iff (srst)
      $rose(sequence_active_flag) && format_bits_latch[1]);
   c_full_ratio: cover property (@(posedge clock) disable iff (srst)
      ratio[mfr_pkg::RATIO_W-1] && first_read);
endmodule

// ### common/mfr_pkg.sv
// constants, codes and types shared by the reply data generator
//
// Contract
// - five-bit long ratio, values above sixteen saturate
// - low bits compared, top bit ORed in
// - short replies end after 56 bits
// - flight status 0..5, downlink request 0..1
// - identity and A/B/C bits are uniform
// - D1, D2 zero; D4 one in eight
// - M position always zero
// - all-call: capability 0..3, parity identifier zero
// - first word from 512-entry shaping table
// - two byte selectors: random, shaped, zero
// - three format bits choose six words
// - first, fifth, second bit meaning, second overrides
// - format bits latched at first word read
// - trailing command starts sequence, sets active
// - trailing source advances once per word
// - active flag clears after six words
// - leading read four words, trailing six
// - reset command reseeds every random source
package mfr_pkg;
   // ************************************************************
   // register map
   // ************************************************************
   localparam int APB_ADDR_W = 4;
   localparam logic [APB_ADDR_W-1:0] RATIO_OFS = 4'h0;
   localparam logic [APB_ADDR_W-1:0] STATUS_OFS = 4'h4;
   localparam int RATIO_W = 5;
   localparam logic [RATIO_W-1:0] RATIO_RST = 5'h00;
   localparam int ST_SEQ_BIT = 0;
   localparam int ST_LONG_BIT = 1;
   localparam int ST_FMT_LSB = 2;
   localparam int ST_LEAD_BIT = 5;
   // ************************************************************
   // word layout
   // ************************************************************
   localparam int WORD_W = 16;
   localparam int STEP_W = 3;
   localparam logic [STEP_W-1:0] LEAD_LAST = 3'h3;
   localparam logic [STEP_W-1:0] TRAIL_LAST = 3'h5;
   localparam logic [STEP_W-1:0] FIRST_WORD_STEP = 3'h3;
   localparam logic [4:0] DF_SURV_ALT = 5'h04;
   localparam logic [4:0] DF_SURV_ID = 5'h05;
   localparam logic [4:0] DF_ALL_CALL = 5'h0B;
   localparam logic [4:0] DF_COMMB_ALT = 5'h14;
   localparam logic [4:0] DF_COMMB_ID = 5'h15;
   localparam int DF_LSB = 11;
   localparam int FS_LSB = 8;
   localparam int DR_LSB = 3;
   localparam logic [2:0] FS_MAX = 3'h5;
   localparam logic [6:0] FSDR_MOD = 7'h0C;
   localparam int FMT_B1 = 4;
   localparam int FMT_B2 = 3;
   localparam int FMT_B5 = 0;
   localparam logic [7:0] ID_MASK = 8'hBF;
   localparam logic [7:0] AC_MASK = 8'hAA;
   // ************************************************************
   // random sources
   // ************************************************************
   localparam int LS_W = 7;
   localparam logic [LS_W-1:0] LS_TAPS = 7'h60;
   localparam logic [LS_W-1:0] LS_SEED = 7'h5A;
   localparam int FW_W = 9;
   localparam logic [FW_W-1:0] FW_TAPS = 9'h110;
   localparam logic [FW_W-1:0] FW_SEED = 9'h1A5;
   localparam int TW_W = 21;
   localparam logic [TW_W-1:0] TW_TAPS = 21'h140000;
   localparam logic [TW_W-1:0] TW_SEED = 21'h0ACE1;
   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      SEL_RND = 2'b00,
      SEL_ID = 2'b01,
      SEL_AC = 2'b10,
      SEL_ZERO = 2'b11
   } mfr_sel_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_TRAIL = 2'b10
   } mfr_state_type;
endpackage

// ### src/mfr_lfsr.sv
// galois shift register random source with reseed
`timescale 1ns/1ps
module mfr_lfsr #(
   parameter int W = 7,
   parameter logic [W-1:0] TAPS = '1,
   parameter logic [W-1:0] SEED = '1
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   input wire logic reseed,
   input wire logic advance,
   output logic [W-1:0] state
);
   // ************************************************************
   // shift register
   // ************************************************************
   // reseed wins over advance; never reaches the all-zero lockup
   always_ff @(posedge clock)
   begin
      if (srst)
         state <= SEED;
      else if (ce)
      begin
         if (reseed)
            state <= SEED;
         else if (advance)
            state <= state[0] ? ((state >> 1) ^ TAPS) : (state >> 1);
      end
   end
endmodule

// ### src/mfr_first_word_rom.sv
// shaping table for the first reply word
`timescale 1ns/1ps
module mfr_first_word_rom (
   input wire logic [8:0] addr,
   output logic [15:0] data
);
   logic [6:0] fsdr;
   logic [4:0] df;
   // ************************************************************
   // table decode
   // ************************************************************
   // lower half long, upper half short; fs/dr pairs folded mod 12
   always_comb
   begin
      fsdr = 7'h00;
      df = mfr_pkg::DF_SURV_ALT;
      data = 16'h0000;
      if (!addr[8])
      begin
         fsdr = addr[6:0] % mfr_pkg::FSDR_MOD;
         df = addr[7] ? mfr_pkg::DF_COMMB_ID : mfr_pkg::DF_COMMB_ALT;
      end
      else
      begin
         fsdr = {1'b0, addr[5:0]} % mfr_pkg::FSDR_MOD;
         case (addr[7:6])
            2'b01: df = mfr_pkg::DF_SURV_ID;
            2'b10: df = mfr_pkg::DF_ALL_CALL;
            default: df = mfr_pkg::DF_SURV_ALT;
         endcase
      end
      data[15:11] = df;
      if (df == mfr_pkg::DF_ALL_CALL)
      begin
         data[10:8] = {1'b0, addr[1:0]};
         data[7:0] = {addr[5:0], addr[3:2]};
      end
      else
      begin
         data[10:8] = fsdr[3:1];
         data[mfr_pkg::DR_LSB] = fsdr[0];
         data[2:0] = addr[2:0];
      end
   end
endmodule

// ### sim/mfr_ctrl_model.sv
// fruit reply controller model: issues read commands, takes words
`timescale 1ns/1ps
module mfr_ctrl_model (
   input wire logic clock,
   input wire logic word_valid,
   input wire logic [15:0] word_data,
   output logic lead_cmd,
   output logic trail_cmd
);
   logic [15:0] got [6];
   int got_n;
   int gap;
   // ***********
   // read command and word capture
   // ***********
   // one command pulse, then words are taken off the bus on each edge
   task automatic fetch(input bit trail);
      int n;
      int k;
      n = trail ? 6 : 4;
      got_n = 0;
      gap = 0;
      @(posedge clock);
      lead_cmd <= !trail;
      trail_cmd <= trail;
      @(posedge clock);
      lead_cmd <= 1'b0;
      trail_cmd <= 1'b0;
      for (k = 0; k < 12 && got_n < n; k++)
      begin
         @(posedge clock);
         if (word_valid === 1'b1)
         begin
            got[got_n] = word_data;
            got_n++;
         end
         else if (got_n > 0)
            gap++;
      end
   endtask
   // commands idle from time zero
   initial
   begin
      lead_cmd = 1'b0;
      trail_cmd = 1'b0;
   end
endmodule

// ### sim/mfr_modes_fruit_reply_data_gen_test.sv
// self-checking bench for the reply data generator
`timescale 1ns/1ps
module mfr_modes_fruit_reply_data_gen_test;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [mfr_pkg::APB_ADDR_W-1:0] paddr = 4'h0;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cmd_reset = 1'b0;
   logic ce = 1'b1;
   logic lead_cmd;
   logic trail_cmd;
   logic [15:0] pw [3] = '{16'h0000, 16'h0000, 16'h0000};
   logic [15:0] word_data;
   logic word_valid;
   logic [31:0] rd;
   logic [31:0] keep;
   logic err;
   logic [15:0] fw;
   logic [4:0] ratio;
   logic [4:0] df;
   int mismatches = 0;
   int compares = 0;
   int i;
   int k;
   // ***********
   // design, far side and helpers
   // ***********
   mfr_modes_fruit_reply_data_gen dut (.clock(clock), .srst(srst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cmd_reset(cmd_reset),
      .leading_words_read_cmd(lead_cmd), .trailing_words_read_cmd(trail_cmd),
      .param_word0(pw[0]), .param_word1(pw[1]), .param_word2(pw[2]),
      .word_data(word_data), .word_valid(word_valid));
   mfr_ctrl_model model (.clock(clock), .word_valid(word_valid), .word_data(word_data),
      .lead_cmd(lead_cmd), .trail_cmd(trail_cmd));
   // clock at 100 MHz
   always #5 clock = ~clock;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // apb transfer, request held until pready is sampled high
   task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      // no cycle count assumed: the watchdog ends a hung wait
      do
         @(posedge clock);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // format codes a ratio may yield
   function automatic logic df_ok(input logic [4:0] f, input logic [4:0] r);
      logic s;
      logic l;
      s = f == mfr_pkg::DF_SURV_ALT || f == mfr_pkg::DF_SURV_ID || f == mfr_pkg::DF_ALL_CALL;
      l = f == mfr_pkg::DF_COMMB_ALT || f == mfr_pkg::DF_COMMB_ID;
      return (r == 5'h00) ? s : (r[4] ? l : (s || l));
   endfunction
   // bits that must be zero in trailing word k
   function automatic logic [15:0] zero_bits(input logic [4:0] f, input int k);
      logic [15:0] m;
      m = f[0] ? 16'h0040 : 16'h0054;
      if (f == mfr_pkg::DF_ALL_CALL)
         return (k == 0) ? 16'h0000 : 16'hFFFF;
      if (k == 0)
         return m;
      if (f[4] || k == 1)
         return 16'h0000;
      return (k == 2) ? 16'h00FF : 16'hFFFF;
   endfunction
   // watchdog
   initial
   begin
      #200000;
      mismatches++;
      test_done;
   end
   // main sequence
   initial
   begin
      k = $urandom(32'hA19C);
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      apb(1'b0, mfr_pkg::STATUS_OFS, 32'h00000000);
      check(rd, 32'h00000000);
      apb(1'b1, 4'h8, 32'hFFFFFFFF);
      check({31'h0, err}, 32'h00000001);
      apb(1'b0, mfr_pkg::RATIO_OFS, 32'h00000000);
      check(rd, 32'h00000000);
      for (i = 0; i < 24; i++)
      begin
         ratio = (i < 3) ? 5'h00 : ((i < 6) ? 5'(13 + i) : 5'($urandom));
         for (k = 0; k < 3; k++)
            pw[k] <= 16'($urandom);
         apb(1'b1, mfr_pkg::RATIO_OFS, {27'h0, ratio});
         apb(1'b0, mfr_pkg::RATIO_OFS, 32'h00000000);
         check(rd, {27'h0, ratio});
         model.fetch(1'b0);
         check(model.got_n + model.gap, 4);
         for (k = 0; k < 3; k++)
            check(model.got[k], pw[k]);
         fw = model.got[3];
         df = fw[15:11];
         check(df_ok(df, ratio), 1'b1);
         check(fw[10:8] <= ((df == mfr_pkg::DF_ALL_CALL) ? 3 : 5), 1'b1);
         check(df == mfr_pkg::DF_ALL_CALL || fw[7:3] <= 1, 1'b1);
         apb(1'b0, mfr_pkg::STATUS_OFS, 32'h00000000);
         check(rd[4:2], {df[4], df[3], df[0]});
         if (ratio == 5'h00 || ratio[4])
            check(rd[1:0], {ratio[4], 1'b0});
         fork
            model.fetch(1'b1);
            begin
               repeat (2) @(posedge clock);
               apb(1'b0, mfr_pkg::STATUS_OFS, 32'h00000000);
            end
         join
         check(rd[0], 1'b1);
         check(model.got_n + model.gap, 6);
         for (k = 0; k < 6; k++)
            check(model.got[k] & zero_bits(df, k), 16'h0000);
         check(df == mfr_pkg::DF_ALL_CALL || model.got[0] != model.got[1] ||
            model.got[1] != model.got[2], 1'b1);
         apb(1'b0, mfr_pkg::STATUS_OFS, 32'h00000000);
         check(rd[0], 1'b0);
      end
      // clock enable low freezes the sequencer: a trailing command yields no words
      ce <= 1'b0;
      model.fetch(1'b1);
      check(model.got_n, 0);
      ce <= 1'b1;
      // a reset command replays the same reply
      for (i = 0; i < 2; i++)
      begin
         @(posedge clock);
         cmd_reset <= 1'b1;
         @(posedge clock);
         cmd_reset <= 1'b0;
         model.fetch(1'b0);
         fw = model.got[3];
         model.fetch(1'b1);
         if (i == 0)
            keep = {fw, model.got[5]};
         else
            check({fw, model.got[5]}, keep);
      end
      test_done;
   end
endmodule
